// file: logic/power_up_consts.vh
// constants for the input power-up sequencer
// assumes a 100 MHz system clock and a 500 kHz internal digital tick
`ifndef POWER_UP_CONSTS_VH
`define POWER_UP_CONSTS_VH

`define CLK_HZ              100000000
`define TICK_HZ             500000
`define TICK_DIV            (`CLK_HZ / `TICK_HZ)
`define TICK_DIV_W          8
`define CNT_W               20
`define REG_DELAY_MS        220
`define QUAL_WINDOW_MS      30
`define RETRY_MS            2000
`define BOOST_DELAY_MS      30
`define MS_TICKS(m)         ((m) * (`TICK_HZ / 1000))
`define REG_DELAY_TICKS     `MS_TICKS(`REG_DELAY_MS)
`define QUAL_TICKS          `MS_TICKS(`QUAL_WINDOW_MS)
`define RETRY_TICKS         `MS_TICKS(`RETRY_MS)
`define BOOST_TICKS         `MS_TICKS(`BOOST_DELAY_MS)

// register addresses (word index)
`define ADDR_W              4
`define ADDR_CTRL           4'h0
`define ADDR_ILIM           4'h1
`define ADDR_VLIM           4'h2
`define ADDR_DRIVE          4'h3
`define ADDR_STATUS         4'h4
`define ADDR_BOOST          4'h5

// control register bits
`define CTRL_KICK           0
`define CTRL_FORCE          1
`define CTRL_CHG_EN         2
`define CTRL_PSKIP_DIS      3
`define CTRL_VARIANT_DP     4

// input current limit codes, 100 mA per step
`define ILIM_W              5
`define ILIM_200MA          5'h02
`define ILIM_500MA          5'h05
`define ILIM_1000MA         5'h0A
`define ILIM_1500MA         5'h0F
`define ILIM_2000MA         5'h14
`define ILIM_2100MA         5'h15
`define ILIM_2400MA         5'h18

// input voltage limit: code in 100 mV steps above 3.9 V
`define VLIM_W              8
`define VLIM_DEFAULT        8'h06
`define TRACK_200MV         8'h02
`define TRACK_250MV         8'h03
`define TRACK_300MV         8'h03

// source type codes
`define SRC_NONE            3'h0
`define SRC_SDP             3'h1
`define SRC_ADAPTOR         3'h2
`define SRC_CDP             3'h3
`define SRC_DCP             3'h4
`define SRC_NONSTD          3'h5
`define SRC_UNKNOWN         3'h6
`define SRC_BOOST           3'h7

// d+/d- detector result codes
`define DET_SDP             3'h0
`define DET_CDP             3'h1
`define DET_DCP             3'h2
`define DET_DIV1            3'h3
`define DET_DIV2            3'h4
`define DET_DIV3            3'h5
`define DET_DIV4            3'h6
`define DET_UNKNOWN         3'h7

`endif

// file: logic/input_power_up_sequencer.v
// input power-up sequencer: regulator, qualification, type detection,
// limits, converter start and boost entry
// assumes analog comparators are synchronous levels from the front end
`timescale 1ns/1ns
`default_nettype none
`include "power_up_consts.vh"

// How it works
// - steps run regulator, qualify, detect, voltage limit, then converter start
// - regulator enables after presence and sleep comparator hold 220 ms
// - qualification draws 30 mA load for 30 ms, bus must stay in range
// - failed qualification retries every two seconds
// - pass sets source good flag and pulses host interrupt once
// - detection runs only with regulator on and source good set
// - detection done loads limit, sets power good, type code, pulses irq
// - input current capped by five-bit limit field, host may overwrite
// - select pin updates limit continuously by default, on force in host mode
// - pin high 500 mA code 001, pin low 2400 mA code 010
// - d+/d- runs standard detection, then non-standard on contact timeout
// - sdp 500 mA, cdp 1.5 A, dcp 2.4 A, unknown 500 mA
// - divider classes map to 2.1 A, 2 A, 1 A, 2.4 A
// - force detect bit reruns detection and self clears when done
// - d+/d- drive selects ignored while standard or non-standard detection runs
// - tracking uses max of limit and battery plus offset, only offset 00
// - system below 2.2 V caps input current at min of 200 mA and limit
// - run state keeps battery switch on only when charging enabled, other states keep it on
// - in run, pulse skip only when charge off or battery low, disable bit blocks it
// - boost after enable held 30 ms, battery ok, bus asleep, thermistor ok
// - boost current select 0.5 A or 1.2 A, type code reads 111
// - boost starts pulse skipping then fixed frequency unless disabled
// - watchdog kick moves device from default mode to host mode
module input_power_up_sequencer (
  input  wire              i_clock,
  input  wire              i_rst_b,
  input  wire              i_clk_en,
  input  wire [3:0]        i_addr,
  input  wire [7:0]        i_wdata,
  input  wire              i_wr,
  input  wire              i_rd,
  output reg  [7:0]        o_rdata,
  input  wire              i_input_present,
  input  wire              i_sleep_ok,
  input  wire              i_bus_ovp,
  input  wire              i_bus_above_min,
  input  wire              i_select_pin,
  input  wire              i_det_done,
  input  wire [2:0]        i_det_result,
  input  wire              i_dcd_timeout,
  input  wire              i_sys_low,
  input  wire              i_bat_low_sys,
  input  wire              i_bat_above_boost,
  input  wire              i_bus_asleep,
  input  wire              i_thermistor_ok,
  input  wire [7:0]        i_bat_vlim_code,
  output reg               o_regulator_en,
  output reg               o_test_load_en,
  output reg               o_host_irq_pulse,
  output reg               o_bc_detect_start,
  output reg               o_nonstd_detect_start,
  output reg  [1:0]        o_dplus_drive,
  output reg  [1:0]        o_dminus_drive,
  output reg  [4:0]        o_ilim_applied,
  output reg  [7:0]        o_vlim_applied,
  output reg               o_converter_en,
  output reg               o_battery_switch,
  output reg               o_pulse_skip_en,
  output reg               o_boost_en,
  output reg               o_boost_ilim_high
);

  // ===========================================================
  // state codes and registers
  localparam [7:0] S_OFF    = 8'h01;
  localparam [7:0] S_REGWT  = 8'h02;
  localparam [7:0] S_QUAL   = 8'h04;
  localparam [7:0] S_RETRY  = 8'h08;
  localparam [7:0] S_DETECT = 8'h10;
  localparam [7:0] S_NONSTD = 8'h20;
  localparam [7:0] S_RUN    = 8'h40;
  localparam [7:0] S_BOOST  = 8'h80;

  reg [7:0]            state_reg;
  reg [`TICK_DIV_W-1:0] div_reg;
  reg                  tick_reg;
  reg [`CNT_W-1:0]     cnt_reg;
  reg [`CNT_W-1:0]     boost_cnt_reg;
  reg                  host_mode_reg;
  reg                  force_reg;
  reg                  chg_en_reg;
  reg                  pskip_dis_reg;
  reg                  variant_dp_reg;
  reg [4:0]            ilim_reg;
  reg [7:0]            vlim_reg;
  reg [1:0]            vlim_os_reg;
  reg [1:0]            track_reg;
  reg [1:0]            dp_sel_reg;
  reg [1:0]            dm_sel_reg;
  reg                  src_good_reg;
  reg                  pwr_good_reg;
  reg [2:0]            src_type_reg;
  reg                  boost_sel_reg;
  reg                  boost_req_reg;
  reg                  boost_pfm_reg;

  wire power_ok  = i_input_present & i_sleep_ok;
  wire bus_ok    = ~i_bus_ovp & i_bus_above_min;
  wire boost_ok  = boost_req_reg & i_bat_above_boost & i_bus_asleep &
                   i_thermistor_ok;
  wire wr_ctrl   = i_wr & (i_addr == `ADDR_CTRL);
  wire det_cycle = (state_reg == S_DETECT) | (state_reg == S_NONSTD);

  // ===========================================================
  // detection result lookup
  reg [4:0] det_ilim;
  reg [2:0] det_type;
  always @* begin
    case (i_det_result)
      `DET_SDP:  begin det_ilim = `ILIM_500MA;  det_type = `SRC_SDP; end
      `DET_CDP:  begin det_ilim = `ILIM_1500MA; det_type = `SRC_CDP; end
      `DET_DCP:  begin det_ilim = `ILIM_2400MA; det_type = `SRC_DCP; end
      `DET_DIV1: begin det_ilim = `ILIM_2100MA; det_type = `SRC_NONSTD; end
      `DET_DIV2: begin det_ilim = `ILIM_2000MA; det_type = `SRC_NONSTD; end
      `DET_DIV3: begin det_ilim = `ILIM_1000MA; det_type = `SRC_NONSTD; end
      `DET_DIV4: begin det_ilim = `ILIM_2400MA; det_type = `SRC_NONSTD; end
      default:   begin det_ilim = `ILIM_500MA;  det_type = `SRC_UNKNOWN; end
    endcase
  end

  wire [4:0] pin_ilim = i_select_pin ? `ILIM_500MA : `ILIM_2400MA;
  wire [2:0] pin_type = i_select_pin ? `SRC_SDP : `SRC_ADAPTOR;

  reg [7:0] track_add;
  always @* begin
    case (track_reg)
      2'h1:    track_add = `TRACK_200MV;
      2'h2:    track_add = `TRACK_250MV;
      2'h3:    track_add = `TRACK_300MV;
      default: track_add = 8'h00;
    endcase
  end
  // saturate so a high battery code cannot wrap to a low limit
  wire [8:0] bat_sum   = {1'b0, i_bat_vlim_code} + {1'b0, track_add};
  wire [7:0] bat_track = bat_sum[8] ? 8'hFF : bat_sum[7:0];

  // ===========================================================
  // digital tick
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_reg  <= {`TICK_DIV_W{1'b0}};
      tick_reg <= 1'b0;
    end else if (i_clk_en) begin
      tick_reg <= (div_reg == `TICK_DIV - 1);
      if (div_reg == `TICK_DIV - 1)
        div_reg <= {`TICK_DIV_W{1'b0}};
      else
        div_reg <= div_reg + 1'b1;
    end
  end

  // ===========================================================
  // sequencer and registers
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg             <= S_OFF;
      cnt_reg               <= {`CNT_W{1'b0}};
      boost_cnt_reg         <= {`CNT_W{1'b0}};
      host_mode_reg         <= 1'b0;
      force_reg             <= 1'b0;
      chg_en_reg            <= 1'b1;
      pskip_dis_reg         <= 1'b0;
      variant_dp_reg        <= 1'b0;
      ilim_reg              <= `ILIM_500MA;
      vlim_reg              <= `VLIM_DEFAULT;
      vlim_os_reg           <= 2'h0;
      track_reg             <= 2'h0;
      dp_sel_reg            <= 2'h0;
      dm_sel_reg            <= 2'h0;
      src_good_reg          <= 1'b0;
      pwr_good_reg          <= 1'b0;
      src_type_reg          <= `SRC_NONE;
      boost_sel_reg         <= 1'b1;
      boost_req_reg         <= 1'b0;
      boost_pfm_reg         <= 1'b0;
      o_rdata               <= 8'h00;
      o_host_irq_pulse      <= 1'b0;
      o_bc_detect_start     <= 1'b0;
      o_nonstd_detect_start <= 1'b0;
    end else if (i_clk_en) begin
      o_host_irq_pulse      <= 1'b0;
      o_bc_detect_start     <= 1'b0;
      o_nonstd_detect_start <= 1'b0;
      // register writes
      if (wr_ctrl) begin
        if (i_wdata[`CTRL_KICK])
          host_mode_reg <= 1'b1;
        if (i_wdata[`CTRL_FORCE] & host_mode_reg)
          force_reg <= 1'b1;
        chg_en_reg     <= i_wdata[`CTRL_CHG_EN];
        pskip_dis_reg  <= i_wdata[`CTRL_PSKIP_DIS];
        variant_dp_reg <= i_wdata[`CTRL_VARIANT_DP];
      end
      if (i_wr & (i_addr == `ADDR_ILIM))
        ilim_reg <= i_wdata[4:0];
      if (i_wr & (i_addr == `ADDR_VLIM)) begin
        vlim_reg    <= {4'h0, i_wdata[3:0]};
        vlim_os_reg <= i_wdata[5:4];
        track_reg   <= i_wdata[7:6];
      end
      if (i_wr & (i_addr == `ADDR_DRIVE)) begin
        dp_sel_reg <= i_wdata[1:0];
        dm_sel_reg <= i_wdata[3:2];
      end
      if (i_wr & (i_addr == `ADDR_BOOST)) begin
        boost_req_reg <= i_wdata[0];
        boost_sel_reg <= i_wdata[1];
      end
      // register reads
      if (i_rd) begin
        case (i_addr)
          `ADDR_CTRL:   o_rdata <= {3'h0, variant_dp_reg, pskip_dis_reg,
                                    chg_en_reg, force_reg, host_mode_reg};
          `ADDR_ILIM:   o_rdata <= {3'h0, ilim_reg};
          `ADDR_VLIM:   o_rdata <= {track_reg, vlim_os_reg, vlim_reg[3:0]};
          `ADDR_DRIVE:  o_rdata <= {4'h0, dm_sel_reg, dp_sel_reg};
          `ADDR_STATUS: o_rdata <= {2'h0, state_reg == S_BOOST,
                                    pwr_good_reg, src_good_reg, src_type_reg};
          `ADDR_BOOST:  o_rdata <= {6'h00, boost_sel_reg, boost_req_reg};
          default:      o_rdata <= 8'h00;
        endcase
      end
      // boost enable hold timer
      if (!boost_req_reg)
        boost_cnt_reg <= {`CNT_W{1'b0}};
      else if (tick_reg && boost_cnt_reg < `BOOST_TICKS)
        boost_cnt_reg <= boost_cnt_reg + 1'b1;
      // select pin tracking in default mode
      if (!variant_dp_reg && pwr_good_reg && !host_mode_reg &&
          state_reg == S_RUN) begin
        ilim_reg     <= pin_ilim;
        src_type_reg <= pin_type;
      end
      case (state_reg)
        S_OFF: begin
          cnt_reg <= {`CNT_W{1'b0}};
          if (power_ok)
            state_reg <= S_REGWT;
        end
        S_REGWT: begin
          if (!power_ok) begin
            state_reg <= S_OFF;
          end else if (cnt_reg >= `REG_DELAY_TICKS) begin
            cnt_reg   <= {`CNT_W{1'b0}};
            state_reg <= S_QUAL;
          end else if (tick_reg) begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        S_QUAL: begin
          if (!bus_ok) begin
            cnt_reg   <= {`CNT_W{1'b0}};
            state_reg <= S_RETRY;
          end else if (cnt_reg >= `QUAL_TICKS) begin
            src_good_reg      <= 1'b1;
            o_host_irq_pulse  <= 1'b1;
            o_bc_detect_start <= variant_dp_reg;
            state_reg         <= S_DETECT;
          end else if (tick_reg) begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        S_RETRY: begin
          if (cnt_reg >= `RETRY_TICKS) begin
            cnt_reg   <= {`CNT_W{1'b0}};
            state_reg <= S_QUAL;
          end else if (tick_reg) begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        S_DETECT, S_NONSTD: begin
          // wait out the pass pulse so the two irq pulses stay apart
          if (!o_host_irq_pulse && (!variant_dp_reg || i_det_done)) begin
            ilim_reg         <= variant_dp_reg ? det_ilim : pin_ilim;
            src_type_reg     <= variant_dp_reg ? det_type : pin_type;
            pwr_good_reg     <= 1'b1;
            o_host_irq_pulse <= 1'b1;
            force_reg        <= wr_ctrl & i_wdata[`CTRL_FORCE] &
                                host_mode_reg;
            state_reg        <= S_RUN;
          end else if (i_dcd_timeout && state_reg == S_DETECT) begin
            o_nonstd_detect_start <= 1'b1;
            state_reg             <= S_NONSTD;
          end
        end
        S_RUN: begin
          if (force_reg) begin
            o_bc_detect_start <= variant_dp_reg;
            state_reg         <= S_DETECT;
          end else if (boost_ok && boost_cnt_reg >= `BOOST_TICKS &&
                       !i_input_present) begin
            src_type_reg  <= `SRC_BOOST;
            boost_pfm_reg <= ~pskip_dis_reg;
            state_reg     <= S_BOOST;
          end
        end
        S_BOOST: begin
          if (tick_reg)
            boost_pfm_reg <= 1'b0;
          if (!boost_ok) begin
            src_type_reg <= `SRC_NONE;
            state_reg    <= S_OFF;
          end
        end
        default: state_reg <= S_OFF;
      endcase
      // source gone in off, regulator wait or retry: back to high impedance
      if ((state_reg == S_OFF || state_reg == S_REGWT ||
           state_reg == S_RETRY) && !power_ok) begin
        src_good_reg <= 1'b0;
        pwr_good_reg <= 1'b0;
        state_reg    <= S_OFF;
      end
    end
  end

  // ===========================================================
  // registered outputs
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_regulator_en    <= 1'b0;
      o_test_load_en    <= 1'b0;
      o_dplus_drive     <= 2'h0;
      o_dminus_drive    <= 2'h0;
      o_ilim_applied    <= `ILIM_500MA;
      o_vlim_applied    <= `VLIM_DEFAULT;
      o_converter_en    <= 1'b0;
      o_battery_switch  <= 1'b0;
      o_pulse_skip_en   <= 1'b0;
      o_boost_en        <= 1'b0;
      o_boost_ilim_high <= 1'b1;
    end else if (i_clk_en) begin
      o_regulator_en <= (state_reg != S_OFF) && (state_reg != S_REGWT);
      o_test_load_en <= (state_reg == S_QUAL);
      o_dplus_drive  <= det_cycle ? 2'h0 : dp_sel_reg;
      o_dminus_drive <= det_cycle ? 2'h0 : dm_sel_reg;
      o_ilim_applied <= (i_sys_low && ilim_reg > `ILIM_200MA) ?
                        `ILIM_200MA : ilim_reg;
      o_vlim_applied <= (track_reg != 2'h0 && vlim_os_reg == 2'h0 &&
                         bat_track > vlim_reg) ? bat_track : vlim_reg;
      o_converter_en <= (state_reg == S_RUN) || (state_reg == S_BOOST);
      o_battery_switch <= (state_reg == S_RUN) ? chg_en_reg : 1'b1;
      o_pulse_skip_en <= (state_reg == S_BOOST) ?
                         (boost_pfm_reg && !pskip_dis_reg) :
                         (!pskip_dis_reg && (state_reg == S_RUN) &&
                          (!chg_en_reg || i_bat_low_sys));
      o_boost_en        <= (state_reg == S_BOOST);
      o_boost_ilim_high <= boost_sel_reg;
    end
  end

endmodule
`default_nettype wire

// file: bench/seq_checker_properties.sv
// concurrent properties on the ports of the input power-up sequencer
// assumes the shared constants header and a bind onto the sequencer top
`timescale 1ns/1ns
`default_nettype none
`include "power_up_consts.vh"
module seq_checker (
  input wire logic       i_clock,
  input wire logic       i_rst_b,
  input wire logic       i_clk_en,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_input_present,
  input wire logic       i_sleep_ok,
  input wire logic       i_sys_low,
  input wire logic       i_bat_above_boost,
  input wire logic       i_bus_asleep,
  input wire logic       i_thermistor_ok,
  input wire logic       o_regulator_en,
  input wire logic       o_test_load_en,
  input wire logic       o_host_irq_pulse,
  input wire logic       o_bc_detect_start,
  input wire logic       o_nonstd_detect_start,
  input wire logic       o_converter_en,
  input wire logic [4:0] o_ilim_applied,
  input wire logic       o_pulse_skip_en,
  input wire logic       o_boost_en
);
  localparam int REG_MIN   = (`REG_DELAY_TICKS - 1) * `TICK_DIV;
  localparam int BOOST_MIN = (`BOOST_TICKS - 1) * `TICK_DIV;
  logic [24:0] hold_cnt_reg;
  logic [24:0] boost_cnt_reg;
  logic        boost_bit_reg;
  logic        pskip_bit_reg;
  // ====================================================================
  // qualified clock counts, restarted when the condition drops
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hold_cnt_reg  <= 25'h0000000;
      boost_cnt_reg <= 25'h0000000;
      boost_bit_reg <= 1'b0;
      pskip_bit_reg <= 1'b0;
    end else if (i_clk_en) begin
      hold_cnt_reg  <= (i_input_present && i_sleep_ok) ?
                       hold_cnt_reg + 25'h0000001 : 25'h0000000;
      boost_cnt_reg <= boost_bit_reg ? boost_cnt_reg + 25'h0000001
                                     : 25'h0000000;
      if (i_wr && i_addr == `ADDR_BOOST) boost_bit_reg <= i_wdata[0];
      if (i_wr && i_addr == `ADDR_CTRL)
        pskip_bit_reg <= i_wdata[`CTRL_PSKIP_DIS];
    end
  end
  // ====================================================================
  // properties
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  property p_reg_delay; $rose(o_regulator_en) |-> hold_cnt_reg >= REG_MIN;
  endproperty
  a_reg_delay: assert property (p_reg_delay) else $error("regulator early");
  property p_load; o_test_load_en |-> o_regulator_en && !o_converter_en;
  endproperty
  a_load: assert property (p_load) else $error("test load out of step");
  property p_irq; o_host_irq_pulse && i_clk_en |=> !o_host_irq_pulse;
  endproperty
  a_irq: assert property (p_irq) else $error("irq pulse too long");
  property p_detect; (o_bc_detect_start || o_nonstd_detect_start) |->
    o_regulator_en ##1 !o_test_load_en; endproperty
  a_detect: assert property (p_detect) else $error("detect too early");
  property p_conv; $rose(o_converter_en) && !o_boost_en |->
    o_regulator_en && !o_test_load_en; endproperty
  a_conv: assert property (p_conv) else $error("converter out of order");
  property p_ilim_low; i_sys_low [*3] ##0 (o_converter_en && !o_boost_en)
    |-> o_ilim_applied <= `ILIM_200MA; endproperty
  a_ilim_low: assert property (p_ilim_low) else $error("low sys limit");
  property p_pskip; $past(pskip_bit_reg) && pskip_bit_reg |-> !o_pulse_skip_en;
  endproperty
  a_pskip: assert property (p_pskip) else $error("pulse skip not blocked");
  property p_boost; $rose(o_boost_en) |-> boost_cnt_reg >= BOOST_MIN &&
    $past(i_bat_above_boost && i_bus_asleep && i_thermistor_ok); endproperty
  a_boost: assert property (p_boost) else $error("boost entry early");
endmodule
bind input_power_up_sequencer seq_checker u_seq_checker (
  .i_clock(i_clock), .i_rst_b(i_rst_b), .i_clk_en(i_clk_en),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_input_present(i_input_present), .i_sleep_ok(i_sleep_ok),
  .i_sys_low(i_sys_low), .i_bat_above_boost(i_bat_above_boost),
  .i_bus_asleep(i_bus_asleep), .i_thermistor_ok(i_thermistor_ok),
  .o_regulator_en(o_regulator_en), .o_test_load_en(o_test_load_en),
  .o_host_irq_pulse(o_host_irq_pulse), .o_bc_detect_start(o_bc_detect_start),
  .o_nonstd_detect_start(o_nonstd_detect_start),
  .o_converter_en(o_converter_en), .o_ilim_applied(o_ilim_applied),
  .o_pulse_skip_en(o_pulse_skip_en), .o_boost_en(o_boost_en));
`default_nettype wire

// file: bench/source_model.sv
// adaptor and d+/d- detector model facing the sequencer
// assumes detect start requests are one clock long
`timescale 1ns/1ns
`default_nettype none
module source_model (
  input  wire logic       i_clock,
  input  wire logic       i_rst_b,
  input  wire logic       i_attach,
  input  wire logic       i_det_start,
  input  wire logic [2:0] i_kind,
  output logic            o_present,
  output logic            o_det_done,
  output logic            o_timeout,
  output logic [2:0]      o_det_result
);
  logic [5:0] wait_cnt_reg;
  assign o_present = i_attach;
  assign o_timeout = o_det_done && (i_kind inside {[3'h3:3'h6]});
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wait_cnt_reg <= 6'h00;
      o_det_done   <= 1'b0;
      o_det_result <= 3'h0;
    end else begin
      o_det_done   <= (wait_cnt_reg == 6'h01);
      // result lines keep changing outside the done cycle
      o_det_result <= (wait_cnt_reg == 6'h01) ? i_kind : ~o_det_result;
      if (i_det_start) begin
        wait_cnt_reg <= 6'h20;
      end else if (wait_cnt_reg != 6'h00) begin
        wait_cnt_reg <= wait_cnt_reg - 6'h01;
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// self-checking bench for the input power-up sequencer
// assumes the source model and the bound property checker are compiled
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        i_clock = 1'b0;
  logic        i_rst_b = 1'b0;
  logic [3:0]  i_addr  = 4'h0;
  logic [7:0]  i_wdata = 8'h00;
  logic        i_wr = 1'b0, i_rd = 1'b0, attach = 1'b0, boost_ok = 1'b0;
  logic        sys_low = 1'b0, bat_low = 1'b0, sel = 1'b0, rd_q = 1'b0;
  logic [7:0]  bat_code = 8'h00, bat_q = 8'h00;
  logic        clk_en = 1'b1, sys_q = 1'b0;
  logic [31:0] seed = 32'h00005A67;
  logic        present, det_done, dcd, seen;
  logic [2:0]  det_res;
  logic [7:0]  o_rdata, vlim, v;
  logic [4:0]  ilim;
  logic [1:0]  dp, dm;
  logic        reg_en, load_en, irq, bc_st, ns_st, conv, bsw, pskip, boost, bhi;
  logic [7:0]  exp_q[$];
  int          err_total = 0;
  int          check_count = 0;
  always #5 i_clock = ~i_clock;
  source_model u_src (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_attach(attach),
    .i_det_start(bc_st | ns_st), .i_kind(3'h2), .o_present(present),
    .o_det_done(det_done), .o_timeout(dcd), .o_det_result(det_res));
  input_power_up_sequencer DUT (.i_clock(i_clock), .i_rst_b(i_rst_b),
    .i_clk_en(clk_en), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_input_present(present),
    .i_sleep_ok(present), .i_bus_ovp(1'b0), .i_bus_above_min(present),
    .i_select_pin(sel), .i_det_done(det_done), .i_det_result(det_res),
    .i_dcd_timeout(dcd), .i_sys_low(sys_low), .i_bat_low_sys(bat_low),
    .i_bat_above_boost(boost_ok), .i_bus_asleep(boost_ok),
    .i_thermistor_ok(boost_ok), .i_bat_vlim_code(bat_code),
    .o_regulator_en(reg_en), .o_test_load_en(load_en),
    .o_host_irq_pulse(irq), .o_bc_detect_start(bc_st),
    .o_nonstd_detect_start(ns_st), .o_dplus_drive(dp), .o_dminus_drive(dm),
    .o_ilim_applied(ilim), .o_vlim_applied(vlim), .o_converter_en(conv),
    .o_battery_switch(bsw), .o_pulse_skip_en(pskip), .o_boost_en(boost),
    .o_boost_ilim_high(bhi));
  // ====================================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clock);
    i_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_clock);
    i_addr <= a;
    i_rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge i_clock);
    i_rd   <= 1'b0;
  endtask
  task automatic watch(input int n);
    seen = 1'b0;
    repeat (n) @(posedge i_clock) seen = seen | reg_en | boost | irq;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ====================================================================
  // random side inputs and read data monitor
  always @(posedge i_clock) begin
    seed     <= xs(seed);
    bat_code <= {1'b0, seed[6:0]};
    bat_q    <= bat_code;
    sys_q    <= sys_low;
    sys_low  <= seed[8];
    bat_low  <= seed[9];
    sel      <= seed[10];
    rd_q     <= i_rd;
    if (rd_q) cmp("rdata", exp_q.pop_front(), o_rdata);
  end
  initial begin
    #1000000;
    err_total++;
    summarize();
  end
  // ====================================================================
  // tests
  initial begin
    repeat (3) @(posedge i_clock);
    cmp("ilim", 8'h05, {3'h0, ilim});
    cmp("vlim", 8'h06, vlim);
    cmp("boost_current_select", 8'h01, {7'h00, bhi});
    cmp("enables", 8'h00, {reg_en, load_en, irq, conv, bsw, pskip, boost, bc_st});
    i_rst_b <= 1'b1;
    rd(4'h0, 8'h04);
    rd(4'h1, 8'h05);
    rd(4'h2, 8'h06);
    rd(4'h3, 8'h00);
    rd(4'h4, 8'h00);
    rd(4'h5, 8'h02);
    rd(4'h6, 8'h00);
    $display("test reset values done");
    wr(4'h0, 8'h06);
    rd(4'h0, 8'h04);
    wr(4'h0, 8'h15);
    rd(4'h0, 8'h15);
    wr(4'h4, 8'hFF);
    rd(4'h4, 8'h00);
    $display("test modes done");
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'h1F : {3'h0, seed[20:16]};
      wr(4'h1, v);
      rd(4'h1, v);
      cmp("ilim_applied", {3'h0, (sys_q && v[4:0] > 5'h02) ? 5'h02 : v[4:0]},
          {3'h0, ilim});
    end
    clk_en <= 1'b0;
    wr(4'h1, ~v);
    clk_en <= 1'b1;
    rd(4'h1, v);
    $display("test current limit field done");
    for (int k = 0; k < 16; k++) begin
      v = 8'(k);
      wr(4'h3, v);
      repeat (2) @(posedge i_clock);
      cmp("dplus", {6'h00, v[1:0]}, {6'h00, dp});
      cmp("dminus", {6'h00, v[3:2]}, {6'h00, dm});
    end
    $display("test drive selects done");
    wr(4'h2, 8'h43);
    repeat (2) @(posedge i_clock);
    cmp("vlim_track", (bat_q + 8'h02 > 8'h03) ? bat_q + 8'h02 : 8'h03,
        vlim);
    wr(4'h2, 8'h53);
    repeat (2) @(posedge i_clock);
    cmp("vlim_offset", 8'h03, vlim);
    $display("test voltage limit done");
    attach <= 1'b1;
    watch(5000);
    attach <= 1'b0;
    cmp("regulator", 8'h00, {7'h00, seen});
    $display("test short attach done");
    wr(4'h5, 8'h01);
    boost_ok <= 1'b1;
    rd(4'h5, 8'h01);
    watch(5000);
    cmp("boost", 8'h00, {7'h00, seen});
    wr(4'h5, 8'h02);
    boost_ok <= 1'b0;
    $display("test early boost done");
    repeat (4) @(posedge i_clock);
    summarize();
  end
endmodule
`default_nettype wire
